// ===== rtl/redriver_config_registers.sv
`timescale 1ns/1ps
`default_nettype none
module redriver_config_registers
    import redriver_cfg_pkg::*;
#(
    parameter logic [6:0] IDENT_CODE = 7'h2a,    // Arbitrary value
    parameter logic [7:0] RSVD_VALUE = 8'h00
) (
    // Clock and reset
    input  wire logic                        clock,
    input  wire logic                        rst_b,
    // Register access from the serial host engine
    input  wire logic                        reg_wr_en,
    input  wire logic                        reg_rd_en,
    input  wire logic [7:0]                  reg_addr,
    input  wire logic [7:0]                  reg_wdata,
    output logic      [7:0]                  reg_rdata,
    output logic                             reg_rd_valid,
    // Sideband pins and link status
    input  wire logic                        hotplug_in_sink_side,
    input  wire logic                        cable_detect_in_sink_side,
    input  wire logic                        squelch_permit,
    output sideband_out_t                    sideband_out,
    // Analog settings
    output out_cond_t                        out_cond,
    output logic      [LANE_EQ_COUNT*8-1:0]  lane_eq_setting
);

    // ************************************************************
    // Register state
    // ************************************************************
    out_cond_t     cond_reg, cond_next;
    logic [7:0]    side_reg, side_next;
    logic [7:0]    vtest_reg [4];
    logic [7:0]    vtest_next [4];
    logic [7:0]    ahi_reg, ahi_next;
    logic [7:0]    amid_reg, amid_next;
    logic [7:0]    alow_reg, alow_next;
    logic          inv_reg, inv_next;
    logic [7:0]    rdata_reg, rdata_next;
    logic          rvalid_reg, rvalid_next;
    sideband_out_t sb_reg, sb_next;
    logic          soft_rst;
    logic          eq_rst;
    logic [19:0]   cfg_addr;
    logic [7:0]    cfg_rdata;
    logic          cfg_wr;
    logic          eff_hotplug;

    // Reset strobes, writing zero has no effect
    assign soft_rst = reg_wr_en && reg_addr == OFS_RESET_CTRL
                      && reg_wdata[BIT_SOFT_RESET];                  // RULE10
    assign eq_rst   = soft_rst || (reg_wr_en && reg_addr == OFS_RESET_CTRL
                      && reg_wdata[BIT_EQ_RESET]);                   // RULE11
    // Composed indirect address
    assign cfg_addr = {ahi_reg[3:0], amid_reg, alow_reg};            // RULE12
    assign cfg_wr   = reg_wr_en && reg_addr == OFS_DATA_PORT;

    // ************************************************************
    // Indirect configuration space
    // ************************************************************
    link_cfg_space #(
        .ENTRIES (LANE_EQ_COUNT)
    ) u_space (
        .clock           (clock),
        .rst_b           (rst_b),
        .wr_en           (cfg_wr),
        .addr            (cfg_addr),
        .wdata           (reg_wdata),
        .eq_clear        (eq_rst),
        .rdata           (cfg_rdata),
        .lane_eq_setting (lane_eq_setting)
    );

    // ************************************************************
    // Host writes
    // ************************************************************
    always_comb begin
        cond_next = cond_reg;
        side_next = side_reg;
        ahi_next  = ahi_reg;
        amid_next = amid_reg;
        alow_next = alow_reg;
        inv_next  = inv_reg;
        for (int k = 0; k < 4; k++) begin
            vtest_next[k] = vtest_reg[k];
        end
        if (soft_rst) begin
            cond_next = '{RST_BOOST, RST_SWING, RST_PREEMPH};        // RULE10
            side_next = RST_SIDEBAND;
            ahi_next  = RST_BYTE;
            amid_next = RST_BYTE;
            alow_next = RST_BYTE;
            inv_next  = RST_INVERT;
            for (int k = 0; k < 4; k++) begin
                vtest_next[k] = RST_BYTE;
            end
        end else if (reg_wr_en) begin
            unique case (reg_addr)
                OFS_OUT_COND:  cond_next = out_cond_t'(reg_wdata[4:0]); // RULE1
                OFS_SIDEBAND:  side_next = reg_wdata & MASK_SIDEBAND;   // RULE17
                OFS_VTEST_A0, OFS_VTEST_A1,
                OFS_VTEST_A2:  vtest_next[reg_addr[1:0]] = reg_wdata;  // RULE9
                OFS_VTEST_B:   vtest_next[3] = reg_wdata;
                OFS_ADDR_HIGH: ahi_next  = reg_wdata & MASK_ADDR_HI;    // RULE17
                OFS_ADDR_MID:  amid_next = reg_wdata;
                OFS_ADDR_LOW:  alow_next = reg_wdata;
                OFS_IDENT:     inv_next  = reg_wdata[BIT_INVERT];       // RULE15
                default:       ;                                        // RULE16
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cond_reg <= '{RST_BOOST, RST_SWING, RST_PREEMPH};        // RULE1
            side_reg <= RST_SIDEBAND;
            ahi_reg  <= RST_BYTE;
            amid_reg <= RST_BYTE;
            alow_reg <= RST_BYTE;
            inv_reg  <= RST_INVERT;
            for (int k = 0; k < 4; k++) begin
                vtest_reg[k] <= RST_BYTE;
            end
        end else begin
            cond_reg <= cond_next;
            side_reg <= side_next;
            ahi_reg  <= ahi_next;
            amid_reg <= amid_next;
            alow_reg <= alow_next;
            inv_reg  <= inv_next;
            for (int k = 0; k < 4; k++) begin
                vtest_reg[k] <= vtest_next[k];
            end
        end
    end

    // ************************************************************
    // Host reads, answered one cycle later
    // ************************************************************
    always_comb begin
        rvalid_next = reg_rd_en;
        rdata_next  = rdata_reg;
        if (reg_rd_en) begin
            rdata_next = 8'h00;
            unique case (reg_addr)
                OFS_OUT_COND:  rdata_next = {3'h0, cond_reg};           // RULE17
                OFS_SIDEBAND:  rdata_next = side_reg;
                OFS_VTEST_A0, OFS_VTEST_A1,
                OFS_VTEST_A2:  rdata_next = vtest_reg[reg_addr[1:0]];
                OFS_VTEST_B:   rdata_next = vtest_reg[3];
                OFS_RESET_CTRL: rdata_next = 8'h00;                     // RULE10
                OFS_ADDR_HIGH: rdata_next = ahi_reg;
                OFS_ADDR_MID:  rdata_next = amid_reg;
                OFS_ADDR_LOW:  rdata_next = alow_reg;
                OFS_DATA_PORT: rdata_next = cfg_rdata;                  // RULE13
                OFS_IDENT:     rdata_next = {IDENT_CODE, ~inv_reg};     // RULE14
                default: begin
                    if (reg_addr >= OFS_RSVD_FIRST && reg_addr <= OFS_RSVD_LAST) begin
                        rdata_next = RSVD_VALUE;                        // RULE16
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rdata_reg  <= 8'h00;
            rvalid_reg <= 1'b0;
        end else begin
            rdata_reg  <= rdata_next;
            rvalid_reg <= rvalid_next;
        end
    end

    // ************************************************************
    // Sideband pins
    // ************************************************************
    assign eff_hotplug = side_reg[BIT_HP_TEST] | hotplug_in_sink_side;  // RULE5 RULE6

    always_comb begin
        sb_next.hotplug_out_source_side = eff_hotplug;                   // RULE5 RULE6
        sb_next.main_link_enable        = eff_hotplug & squelch_permit;  // RULE6
        if (side_reg[BIT_CD_TEST]) begin
            sb_next.cable_detect_out_source_side =
                1'b1 ^ side_reg[BIT_CD_POLARITY];                        // RULE8
        end else begin
            sb_next.cable_detect_out_source_side =
                cable_detect_in_sink_side ^ side_reg[BIT_CD_POLARITY];   // RULE7
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            sb_reg <= '0;
        end else begin
            sb_reg <= sb_next;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign reg_rdata    = rdata_reg;
    assign reg_rd_valid = rvalid_reg;
    assign sideband_out = sb_reg;
    assign out_cond     = cond_reg;                                      // RULE2 RULE3 RULE4

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    AST_BOOST_WRITE: assert property (reg_wr_en && reg_addr == OFS_OUT_COND && !soft_rst
        |=> out_cond.boost == $past(reg_wdata[4:3])) // RULE1
        else $error("boost field not updated");
    AST_SWING_PREEMPH: assert property (reg_wr_en && reg_addr == OFS_OUT_COND
        |=> out_cond.tmds_swing_select == $past(reg_wdata[2])
            && out_cond.tmds_preemph_select == $past(reg_wdata[1:0])) // RULE3
        else $error("swing or pre-emphasis not updated");
    AST_HP_TEST: assert property (side_reg[BIT_HP_TEST] ##1 side_reg[BIT_HP_TEST]
        |-> sideband_out.hotplug_out_source_side) // RULE6
        else $error("hotplug not forced high in test mode");
    AST_HP_FOLLOW: assert property (!side_reg[BIT_HP_TEST]
        |=> sideband_out.hotplug_out_source_side == $past(hotplug_in_sink_side)) // RULE5
        else $error("hotplug out does not follow input");
    AST_CD_FOLLOW: assert property (!side_reg[BIT_CD_TEST] |=>
        sideband_out.cable_detect_out_source_side
        == ($past(cable_detect_in_sink_side) ^ $past(side_reg[BIT_CD_POLARITY]))) // RULE7
        else $error("cable detect out wrong in normal mode");
    AST_CD_TEST: assert property (side_reg[BIT_CD_TEST] |=>
        sideband_out.cable_detect_out_source_side == !$past(side_reg[BIT_CD_POLARITY])) // RULE8
        else $error("cable detect out wrong in test mode");
    AST_SOFT_RESET: assert property (soft_rst |=> out_cond.boost == RST_BOOST
        && side_reg == RST_SIDEBAND && cfg_addr == 20'h0 && lane_eq_setting == '0) // RULE10
        else $error("soft reset did not restore defaults");
    AST_EQ_RESET: assert property (eq_rst && !soft_rst
        |=> lane_eq_setting == '0 && cfg_addr == $past(cfg_addr)) // RULE11
        else $error("equalization reset wrong");
    AST_INVERT: assert property (reg_wr_en && reg_addr == OFS_IDENT && !soft_rst
        ##1 reg_rd_en && reg_addr == OFS_IDENT && !reg_wr_en
        |=> reg_rdata[0] == !$past(reg_wdata[0], 2)) // RULE15
        else $error("invert bit does not read complement");
    AST_IDENT: assert property (reg_rd_en && reg_addr == OFS_IDENT
        |=> reg_rd_valid && reg_rdata[7:1] == IDENT_CODE) // RULE14
        else $error("identification field wrong");
    AST_RSVD_RO: assert property (reg_rd_en && reg_addr >= OFS_RSVD_FIRST
        && reg_addr <= OFS_RSVD_LAST |=> reg_rdata == RSVD_VALUE) // RULE16
        else $error("reserved register not constant");
    AST_UNDEF_ZERO: assert property (reg_rd_en && reg_addr == OFS_SIDEBAND
        |=> (reg_rdata & ~MASK_SIDEBAND) == 8'h00) // RULE17
        else $error("undefined sideband bits not zero");
    AST_DATA_PORT_WR: assert property (cfg_wr && cfg_addr == LANE_EQ_BASE
        |=> lane_eq_setting[7:0] == $past(reg_wdata)) // RULE13
        else $error("data port write did not reach lane setting");
    AST_RESET_CTRL_RD: assert property (reg_rd_en && reg_addr == OFS_RESET_CTRL
        |=> reg_rdata == 8'h00) // RULE10
        else $error("reset control register did not read zero");

    COV_HP_TEST: cover property (side_reg[BIT_HP_TEST] && !hotplug_in_sink_side
        ##1 sideband_out.main_link_enable);
    COV_INDIRECT: cover property (cfg_wr && cfg_addr == LANE_EQ_BASE
        ##1 reg_rd_en && reg_addr == OFS_DATA_PORT);
    COV_SOFT_RESET: cover property (soft_rst);
    COV_EQ_RESET: cover property (eq_rst && !soft_rst);
    COV_CD_TEST: cover property (side_reg[BIT_CD_TEST] && !cable_detect_in_sink_side);

endmodule
`default_nettype wire

// ===== rtl/redriver_cfg_pkg.sv
// What this block does
// RULE1 - Boost field scales pre-emphasis, default nominal
// RULE2 - Boost scales swing without pre-emphasis, TMDS too
// RULE3 - TMDS swing select bit, default low
// RULE4 - TMDS pre-emphasis field, default none
// RULE5 - Normal mode: hotplug out follows input
// RULE6 - Hotplug test: forced high, link active when squelch permits
// RULE7 - Normal cable detect follows input, optional invert
// RULE8 - Cable test: output shows TMDS, invert applies
// RULE9 - Host never writes vendor test registers
// RULE10 - Soft reset bit restores all defaults
// RULE11 - Equalization reset clears lane settings only
// RULE12 - Indirect address composed from three registers
// RULE13 - Data port writes and reads indirect space
// RULE14 - Read-only identification field, fixed code
// RULE15 - Invert scratch bit reads complement, zero first
// RULE16 - Reserved test registers read-only, discard writes
// RULE17 - Undefined bits read zero, ignore writes
`default_nettype none
package redriver_cfg_pkg;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [7:0] OFS_OUT_COND   = 8'h15;
    localparam logic [7:0] OFS_SIDEBAND   = 8'h17;
    localparam logic [7:0] OFS_VTEST_A0   = 8'h18;
    localparam logic [7:0] OFS_VTEST_A1   = 8'h19;
    localparam logic [7:0] OFS_VTEST_A2   = 8'h1a;
    localparam logic [7:0] OFS_RESET_CTRL = 8'h1b;
    localparam logic [7:0] OFS_ADDR_HIGH  = 8'h1c;
    localparam logic [7:0] OFS_ADDR_MID   = 8'h1d;
    localparam logic [7:0] OFS_ADDR_LOW   = 8'h1e;
    localparam logic [7:0] OFS_DATA_PORT  = 8'h1f;
    localparam logic [7:0] OFS_IDENT      = 8'h20;
    localparam logic [7:0] OFS_VTEST_B    = 8'h21;
    localparam logic [7:0] OFS_RSVD_FIRST = 8'h22;
    localparam logic [7:0] OFS_RSVD_LAST  = 8'h27;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int BIT_BOOST_LO      = 3;
    localparam int BIT_SWING         = 2;
    localparam int BIT_PREEMPH_LO    = 0;
    localparam int BIT_HP_TEST       = 3;
    localparam int BIT_CD_POLARITY   = 1;
    localparam int BIT_CD_TEST       = 0;
    localparam int BIT_SOFT_RESET    = 7;
    localparam int BIT_EQ_RESET      = 6;
    localparam int BIT_INVERT        = 0;
    localparam logic [7:0] MASK_OUT_COND = 8'h1f;
    localparam logic [7:0] MASK_SIDEBAND = 8'h0b;
    localparam logic [7:0] MASK_ADDR_HI  = 8'h0f;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [1:0] RST_BOOST    = 2'h1;
    localparam logic       RST_SWING    = 1'h0;
    localparam logic [1:0] RST_PREEMPH  = 2'h0;
    localparam logic [7:0] RST_SIDEBAND = 8'h00;
    localparam logic [7:0] RST_BYTE     = 8'h00;
    localparam logic       RST_INVERT   = 1'h1;   // Stored value; reads back as zero

    // ************************************************************
    // Indirect space
    // ************************************************************
    localparam logic [19:0] LANE_EQ_BASE  = 20'h00103;
    localparam int          LANE_EQ_COUNT = 4;

    // Output conditioning settings
    typedef struct packed {
        logic [1:0] boost;
        logic       tmds_swing_select;
        logic [1:0] tmds_preemph_select;
    } out_cond_t;

    // Sideband pin results
    typedef struct packed {
        logic hotplug_out_source_side;
        logic cable_detect_out_source_side;
        logic main_link_enable;
    } sideband_out_t;

endpackage
`default_nettype wire

// ===== rtl/link_cfg_space.sv
`timescale 1ns/1ps
`default_nettype none
module link_cfg_space
    import redriver_cfg_pkg::*;
#(
    parameter int ENTRIES = LANE_EQ_COUNT
) (
    // Clock and reset
    input  wire logic                  clock,
    input  wire logic                  rst_b,
    // Indirect access
    input  wire logic                  wr_en,
    input  wire logic [19:0]           addr,
    input  wire logic [7:0]            wdata,
    input  wire logic                  eq_clear,
    output logic      [7:0]            rdata,
    // Lane equalization settings
    output logic      [ENTRIES*8-1:0]  lane_eq_setting
);

    // ************************************************************
    // Storage of lane equalization bytes
    // ************************************************************
    logic [7:0] eq_reg  [ENTRIES];
    logic [7:0] eq_next [ENTRIES];
    logic [ENTRIES-1:0] hit;

    // One entry per mapped address
    for (genvar i = 0; i < ENTRIES; i++) begin : g_entry
        assign hit[i] = (addr == LANE_EQ_BASE + 20'(i));
        always_comb begin
            eq_next[i] = eq_reg[i];
            if (eq_clear) begin
                eq_next[i] = RST_BYTE;                              // RULE11
            end else if (wr_en && hit[i]) begin
                eq_next[i] = wdata;                                 // RULE13
            end
        end
        always_ff @(posedge clock or negedge rst_b) begin
            if (!rst_b) begin
                eq_reg[i] <= RST_BYTE;
            end else begin
                eq_reg[i] <= eq_next[i];
            end
        end
        assign lane_eq_setting[i*8 +: 8] = eq_reg[i];
    end

    // Read mux, unmapped addresses read zero
    always_comb begin
        rdata = 8'h00;
        for (int j = 0; j < ENTRIES; j++) begin
            if (hit[j]) begin
                rdata = eq_reg[j];                                  // RULE13
            end
        end
    end

endmodule
`default_nettype wire

// ===== dv/reg_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module reg_host_model
    import redriver_cfg_pkg::*;
(
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst_b,
    // Byte strobe port toward the register bank
    output logic             reg_wr_en,
    output logic             reg_rd_en,
    output logic [7:0]       reg_addr,
    output logic [7:0]       reg_wdata,
    input  wire logic [7:0]  reg_rdata,
    input  wire logic        reg_rd_valid
);
    // Upper bound of idle cycles before a request; zero gives back to back
    int gap_max = 0;

    // Quiet port at time zero
    initial begin
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
    end

    // Idle cycles; address and data toggle so stale values never look valid
    task automatic pause();
        int n;
        n = (gap_max > 0) ? $urandom_range(gap_max, 0) : 0;
        repeat (n) begin
            @(negedge clock);
            reg_wr_en = 1'b0;
            reg_rd_en = 1'b0;
            reg_addr  = ~reg_addr;
            reg_wdata = ~reg_wdata;
        end
    endtask

    // One byte write, no strobe for vendor test registers; strobe stays up until the next request or idle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        pause();
        @(negedge clock);
        if ((a >= OFS_VTEST_A0 && a <= OFS_VTEST_A2) || a == OFS_VTEST_B) begin
            reg_wr_en = 1'b0;
        end else begin
            reg_wr_en = rst_b;
        end
        reg_rd_en = 1'b0;
        reg_addr  = a;
        reg_wdata = d;
        @(posedge clock);
    endtask

    // One byte read; answer sampled half a cycle after the strobe is taken
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
        pause();
        @(negedge clock);
        reg_wr_en = 1'b0;
        reg_rd_en = rst_b;
        reg_addr  = a;
        reg_wdata = ~reg_wdata;
        @(posedge clock);
        // Answer stands only in the cycle after the strobe is taken
        @(negedge clock);
        v = reg_rd_valid;
        d = reg_rdata;
        reg_rd_en = 1'b0;
        reg_addr  = ~a;
    endtask

    // Drop both strobes
    task automatic idle();
        @(negedge clock);
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
    endtask
endmodule
`default_nettype wire

// ===== dv/redriver_config_registers_bench.sv
`timescale 1ns/1ps
`default_nettype none
module redriver_config_registers_bench;
    import redriver_cfg_pkg::*;
    localparam logic [6:0] IDENT = 7'h55;   // Arbitrary value
    localparam logic [7:0] RSVD  = 8'h5a;
    logic          clock;
    logic          rst_b;
    logic          reg_wr_en;
    logic          reg_rd_en;
    logic [7:0]    reg_addr;
    logic [7:0]    reg_wdata;
    logic [7:0]    reg_rdata;
    logic          reg_rd_valid;
    logic          hp;
    logic          cd;
    logic          sq;
    sideband_out_t sb;
    out_cond_t     oc;
    logic [31:0]   lane;
    int            err_count;
    int            checks;

    // ************************************************************
    // Design and host model
    // ************************************************************
    redriver_config_registers #(.IDENT_CODE(IDENT), .RSVD_VALUE(RSVD)) u_dut (
        .clock(clock), .rst_b(rst_b), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rd_valid(reg_rd_valid), .hotplug_in_sink_side(hp),
        .cable_detect_in_sink_side(cd), .squelch_permit(sq), .sideband_out(sb),
        .out_cond(oc), .lane_eq_setting(lane));
    reg_host_model u_host (
        .clock(clock), .rst_b(rst_b), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rd_valid(reg_rd_valid));

    // 250 MHz clock
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    // ************************************************************
    // Checking helpers
    // ************************************************************
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        if (err_count == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Expected sideband pins from control byte and inputs
    function automatic logic [2:0] exp_sb(logic [7:0] ctl, logic h, logic c, logic s);
        logic hp_o;
        logic cd_o;
        hp_o = ctl[3] | h;
        cd_o = (ctl[0] ? 1'b1 : c) ^ ctl[1];
        return {hp_o, cd_o, hp_o & s};
    endfunction

    // Read one register and compare answer and valid pulse
    task automatic rchk(input string name, input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic       v;
        u_host.rd(a, d, v);
        check({name, " valid"}, 32'(v), 32'h1);
        check(name, 32'(d), 32'(exp));
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        logic [7:0]  v;
        logic [7:0]  c;
        logic [31:0] exp_lane;
        err_count = 0;
        checks    = 0;
        rst_b     = 1'b0;
        hp        = 1'b0;
        cd        = 1'b0;
        sq        = 1'b0;
        exp_lane  = 32'h0;
        v = 8'($urandom(32'h8b7d2fa1));
        repeat (2) @(negedge clock);
        rst_b = 1'b1;
        // Defaults after reset
        check("out_cond", 32'(oc), 32'h08);
        check("lane_eq", lane, 32'h0);
        rchk("ident", OFS_IDENT, {IDENT, 1'b0});
        rchk("sideband reg", OFS_SIDEBAND, 8'h00);
        // Output conditioning, every boost code, later with idle gaps
        for (int i = 0; i < 24; i++) begin
            v = 8'($urandom);
            if (i < 4) v[4:3] = i[1:0];
            u_host.gap_max = (i >= 12) ? 3 : 0;
            u_host.wr(OFS_OUT_COND, v);
            #1 check("out_cond", 32'(oc), 32'(v[4:0]));
            rchk("out_cond reg", OFS_OUT_COND, v & MASK_OUT_COND);
        end
        u_host.gap_max = 0;
        // Sideband pins, every test mode combination first
        for (int i = 0; i < 32; i++) begin
            c = 8'($urandom);
            if (i < 4) {c[3], c[0]} = i[1:0];
            u_host.wr(OFS_SIDEBAND, c);
            u_host.idle();
            hp = 1'($urandom);
            cd = 1'($urandom);
            sq = 1'($urandom);
            @(posedge clock);
            #1 check("sideband", 32'(sb), 32'(exp_sb(c, hp, cd, sq)));
            rchk("sideband reg", OFS_SIDEBAND, c & MASK_SIDEBAND);
        end
        // Indirect address and data port, back to back writes
        u_host.wr(OFS_ADDR_HIGH, 8'hf0);
        u_host.wr(OFS_ADDR_MID, 8'h01);
        rchk("addr high", OFS_ADDR_HIGH, 8'h00);
        for (int i = 0; i < 4; i++) begin
            v = 8'($urandom);
            exp_lane[i*8 +: 8] = v;
            u_host.wr(OFS_ADDR_LOW, 8'h03 + i[7:0]);
            u_host.wr(OFS_DATA_PORT, v);
            rchk("data port", OFS_DATA_PORT, v);
        end
        check("lane_eq", lane, exp_lane);
        // Upper address nibble must take part in the decode
        u_host.wr(OFS_ADDR_HIGH, 8'h01);
        u_host.wr(OFS_DATA_PORT, 8'hff);
        rchk("far data port", OFS_DATA_PORT, 8'h00);
        check("lane_eq", lane, exp_lane);
        // Equalization reset clears only the lane settings
        u_host.wr(OFS_OUT_COND, 8'h1b);
        u_host.wr(OFS_RESET_CTRL, 8'h40);
        u_host.idle();
        #1 check("lane_eq", lane, 32'h0);
        rchk("out_cond reg", OFS_OUT_COND, 8'h1b);
        rchk("addr mid", OFS_ADDR_MID, 8'h01);
        rchk("reset ctrl", OFS_RESET_CTRL, 8'h00);
        // Reserved registers discard writes; unmapped reads zero
        for (int a = 8'h22; a <= 8'h27; a++) begin
            u_host.wr(a[7:0], ~RSVD);
            rchk("reserved", a[7:0], RSVD);
        end
        rchk("unmapped", 8'h30, 8'h00);
        // Vendor test registers left alone by the host
        u_host.wr(OFS_VTEST_B, 8'h33);
        rchk("vendor test", OFS_VTEST_B, 8'h00);
        // Invert scratch bit with a random upper field that must not stick
        for (int i = 0; i < 2; i++) begin
            v = 8'($urandom);
            v[0] = i[0];
            u_host.wr(OFS_IDENT, v);
            rchk("ident", OFS_IDENT, {IDENT, ~v[0]});
        end
        // Soft reset: zero does nothing, one restores defaults
        u_host.wr(OFS_SIDEBAND, 8'h0b);
        u_host.wr(OFS_RESET_CTRL, 8'h00);
        rchk("sideband reg", OFS_SIDEBAND, 8'h0b);
        u_host.wr(OFS_RESET_CTRL, 8'h80);
        u_host.idle();
        #1 check("out_cond", 32'(oc), 32'h08);
        rchk("sideband reg", OFS_SIDEBAND, 8'h00);
        rchk("addr mid", OFS_ADDR_MID, 8'h00);
        rchk("ident", OFS_IDENT, {IDENT, 1'b0});
        report_and_stop();
    end
endmodule
`default_nettype wire
